/* adcp_pkg.sv */
/*
  Shared constants for the two-wire converter port: timing, widths and
  channel encodings used by the converter end and the host end.
  Assumes a 50 MHz system clock on both ends.
*/
package adcp_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned SYS_PERIOD_NS = 1_000_000_000 / SYS_CLK_HZ;
  // Least pulse width that must pass the line filter
  localparam int unsigned FILT_MIN_NS = 50;
  // Least time that counts as a real pulse, rounded up
  localparam int unsigned FILT_CYC =
    (FILT_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned FILT_CW = 4;

  // ---------------------------------------------------------------
  // Result word
  // ---------------------------------------------------------------
  localparam int unsigned RES_FULL = 16;
  localparam int unsigned RES_MIN = 10;
  localparam int unsigned MAX_REDUCE = RES_FULL - RES_MIN;
  localparam int unsigned RES_CW = 5;
  localparam int unsigned RED_CW = 3;
  localparam logic [RES_FULL-1:0] CODE_POS_FULL = 16'h7fff;
  localparam logic [RES_FULL-1:0] CODE_NEG_FULL = 16'h8001;
  localparam logic [RES_FULL-1:0] CODE_RESERVED = 16'h8000;

  // Converter internal timing in system clocks
  localparam int unsigned REDUCE_WINDOW_CYC = 2000;
  localparam int unsigned CONV_FULL_CYC = 64000;
  localparam int unsigned TIME_CW = 20;

  // Host link clock half period, in system clocks
  localparam int unsigned HOST_HALF_CYC = 4;
  localparam int unsigned HOST_DIV_CW = 8;

  // Channel index width
  localparam int unsigned CHAN_W = 2;

  // Idle levels of both lines
  localparam logic LINE_IDLE = 1'b1;

endpackage : adcp_pkg

/* adcp_link_if.sv */
/*
  Two-wire link between the host and the converter port.
  The clock line is host driven; the result line is push-pull from the
  converter. Both ends use the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface adcp_link_if;
  logic conv_clk;     // Conversion clock line, host output
  logic result_line;  // Result line, converter output

  modport conv (input conv_clk, output result_line);
  modport host (output conv_clk, input result_line);
endinterface : adcp_link_if

`default_nettype wire

/* adcp_conv.sv */
/*
  Converter end of the two-wire port: start and resolution-reduction
  decode, busy and acknowledge signalling, result shift-out.
  Assumes the host drives the clock line; the analog modulator is
  replaced by a sample word from the user side.
*/
// Notes on behaviour
// - Idle: sleep, both lines high
// - Idle falling edge starts, latches channel
// - Channel select 00..11 maps to 1..4
// - Window falling edge drops one bit, halves time
// - Floor 10 bits; extra reductions ignored
// - Accepted reduction acknowledged by high line
// - Acknowledge ends on clock high or window end
// - Line low as busy during conversion
// - Completion drives line high, sleeps, holds result
// - Each falling edge shifts one bit, sign first
// - Result in two's complement, sign plus magnitude
// - Full code span excludes 8000 reserved code
// - Seventeen falling edges per full cycle
// - Clock line filtered against short pulses
// - High-low-high sampling tells start or reduction
// - Host reads X11 data, X00 ambiguous
// - Host waits for line rise before readout
// - Host resynchronises by hunting start pattern; adcp_host has no such hunt
`timescale 1ns/1ps
`default_nettype none

module adcp_conv #(
  parameter int unsigned REDUCE_WINDOW = adcp_pkg::REDUCE_WINDOW_CYC,
  parameter int unsigned CONV_FULL = adcp_pkg::CONV_FULL_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  adcp_link_if.conv link,
  input wire logic chan_sel_hi,
  input wire logic chan_sel_lo,
  input wire logic [adcp_pkg::RES_FULL-1:0] sample_word,
  output logic [adcp_pkg::CHAN_W-1:0] chan_q,
  output logic busy_q,
  output logic [adcp_pkg::RES_CW-1:0] res_q
);

  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ADCP_SLEEP, ADCP_CONV, ADCP_READY} adcp_st_t;
  adcp_st_t st_q;

  logic clk_s1_q, clk_s2_q, clk_f_q;
  logic [adcp_pkg::FILT_CW-1:0] filt_cnt_q;
  logic [adcp_pkg::TIME_CW-1:0] win_q, dur_q;
  logic [adcp_pkg::RED_CW-1:0] red_q;
  logic [adcp_pkg::RES_FULL-1:0] sh_q;
  logic [adcp_pkg::RES_CW-1:0] left_q;
  logic line_q;
  logic [adcp_pkg::CHAN_W-1:0] sel_s1_q, sel_s2_q;

  // ---------------------------------------------------------------
  // Pin synchroniser and glitch filter
  // ---------------------------------------------------------------
  // Two stages before anything looks at the pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_s1_q <= adcp_pkg::LINE_IDLE;
      clk_s2_q <= adcp_pkg::LINE_IDLE;
    end else begin
      clk_s1_q <= link.conv_clk;
      clk_s2_q <= clk_s1_q;
    end
  end

  // Channel pins settle well before the start edge clears the filter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_s1_q <= '0;
      sel_s2_q <= '0;
    end else begin
      sel_s1_q <= {chan_sel_hi, chan_sel_lo};
      sel_s2_q <= sel_s1_q;
    end
  end

  // Level must differ for FILT_CYC clocks before it is taken
  wire filt_diff = (clk_s2_q != clk_f_q);
  wire filt_take = filt_diff &&
    (filt_cnt_q == adcp_pkg::FILT_CW'(adcp_pkg::FILT_CYC - 1));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      clk_f_q <= adcp_pkg::LINE_IDLE;
      filt_cnt_q <= '0;
    end else begin
      filt_cnt_q <= (filt_diff && !filt_take) ?
        filt_cnt_q + 1'b1 : '0;
      if (filt_take) clk_f_q <= clk_s2_q;
    end
  end

  wire fall = filt_take && clk_f_q;   // Filtered falling edge
  wire rise = filt_take && !clk_f_q;  // Filtered rising edge

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire in_win = (st_q == ADCP_CONV) && (win_q != '0);
  wire can_red = in_win && (red_q != adcp_pkg::RED_CW'(adcp_pkg::MAX_REDUCE));
  wire start = (st_q == ADCP_SLEEP) && fall;
  wire red_acc = fall && can_red;
  wire done = (st_q == ADCP_CONV) && (win_q == '0) && (dur_q == '0);
  wire shift = (st_q == ADCP_READY) && fall && (left_q != '0);

  // Full duration halved once per accepted reduction
  wire [adcp_pkg::TIME_CW-1:0] dur_full = adcp_pkg::TIME_CW'(CONV_FULL);
  wire [adcp_pkg::TIME_CW-1:0] win_full = adcp_pkg::TIME_CW'(REDUCE_WINDOW);

  // Clamp the reserved code to negative full scale
  wire [adcp_pkg::RES_FULL-1:0] code_ok =
    (sample_word == adcp_pkg::CODE_RESERVED) ?
    adcp_pkg::CODE_NEG_FULL : sample_word;

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ADCP_SLEEP;
      chan_q <= '0;
      win_q <= '0;
      dur_q <= '0;
      red_q <= '0;
    end else begin
      unique case (st_q)
        ADCP_SLEEP, ADCP_READY: begin
          if (start || ((st_q == ADCP_READY) && fall && left_q == '0)) begin
            st_q <= ADCP_CONV;
            chan_q <= sel_s2_q;
            win_q <= win_full;
            dur_q <= dur_full;
            red_q <= '0;
          end
        end
        ADCP_CONV: begin
          if (win_q != '0) win_q <= win_q - 1'b1;
          else if (dur_q != '0) dur_q <= dur_q - 1'b1;
          if (red_acc) begin
            red_q <= red_q + 1'b1;
            dur_q <= dur_q >> 1;
          end
          if (done) st_q <= ADCP_READY;
        end
        default: st_q <= ADCP_SLEEP;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Result register and shifter
  // ---------------------------------------------------------------
  // Low bits dropped per reduction; word is left-aligned
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= '0;
      left_q <= '0;
    end else if (done) begin
      sh_q <= code_ok;
      left_q <= adcp_pkg::RES_CW'(adcp_pkg::RES_FULL) -
        adcp_pkg::RES_CW'(red_q);
    end else if (shift) begin
      sh_q <= {sh_q[adcp_pkg::RES_FULL-2:0], 1'b0};
      left_q <= left_q - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Result line drive
  // ---------------------------------------------------------------
  // High after start or reduction until clock rise or window end, so
  // the host tells the two apart by sampling
  wire line_drop = rise || !in_win;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= adcp_pkg::LINE_IDLE;
    end else begin
      if (start) line_q <= 1'b1;    // Start shows 1-1-0
      else if (st_q == ADCP_CONV) begin
        if (done) line_q <= 1'b1;
        else if (red_acc) line_q <= 1'b1;
        else if (line_drop)
          line_q <= 1'b0;                            // Busy
      end else if (shift)
        line_q <= sh_q[adcp_pkg::RES_FULL-1];
      else if (st_q == ADCP_READY && left_q == '0 && rise)
        line_q <= adcp_pkg::LINE_IDLE;  // Rest high after last bit
    end
  end

  assign link.result_line = line_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      res_q <= adcp_pkg::RES_CW'(adcp_pkg::RES_FULL);
    end else begin
      busy_q <= (st_q == ADCP_CONV);
      res_q <= adcp_pkg::RES_CW'(adcp_pkg::RES_FULL) -
        adcp_pkg::RES_CW'(red_q);
    end
  end

endmodule : adcp_conv

`default_nettype wire

/* adcp_host.sv */
/*
  Host end of the two-wire port: issues start and reduction edges,
  waits for completion, clocks the result in, buffers it two deep.
  Assumes the converter end answers per the link protocol.
*/
`timescale 1ns/1ps
`default_nettype none

module adcp_host #(
  parameter int unsigned HALF = adcp_pkg::HOST_HALF_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  adcp_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [adcp_pkg::RED_CW-1:0] req_reduce,
  output logic res_valid,
  input wire logic res_ready,
  output logic [adcp_pkg::RES_FULL-1:0] res_data
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ADCP_IDLE, ADCP_LOW, ADCP_HIGH, ADCP_WAIT, ADCP_PUSH
  } adcp_hst_t;
  adcp_hst_t st_q;
  logic [adcp_pkg::HOST_DIV_CW-1:0] div_q;
  logic [adcp_pkg::RES_CW-1:0] edges_q, nbits_q;
  logic [adcp_pkg::RED_CW-1:0] red_q;
  logic [adcp_pkg::RES_FULL-1:0] acc_q;
  logic clk_q, rl_s1_q, rl_s2_q, rl_s3_q, reading_q;
  logic [adcp_pkg::RES_FULL-1:0] buf_q [2];
  logic wr_q, rd_q;
  logic [1:0] cnt_q;

  // ---------------------------------------------------------------
  // Result line synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rl_s1_q <= adcp_pkg::LINE_IDLE;
      rl_s2_q <= adcp_pkg::LINE_IDLE;
      rl_s3_q <= adcp_pkg::LINE_IDLE;
    end else begin
      rl_s1_q <= link.result_line;
      rl_s2_q <= rl_s1_q;
      rl_s3_q <= rl_s2_q;
    end
  end

  wire tick = (div_q == adcp_pkg::HOST_DIV_CW'(HALF - 1));
  wire full = (cnt_q == 2'h2);
  assign req_ready = (st_q == ADCP_IDLE);
  wire last = (edges_q == '0);
  // Only the reductions the converter can take are sent
  wire [adcp_pkg::RED_CW-1:0] red_clamp =
    (req_reduce > adcp_pkg::RED_CW'(adcp_pkg::MAX_REDUCE)) ?
    adcp_pkg::RED_CW'(adcp_pkg::MAX_REDUCE) : req_reduce;
  // Done is a rise after busy; an ack still high looks alike
  wire rl_rise = rl_s2_q && !rl_s3_q;

  // ---------------------------------------------------------------
  // Link sequencer: only needed reductions, then wait
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ADCP_IDLE;
      div_q <= '0;
      clk_q <= adcp_pkg::LINE_IDLE;
      edges_q <= '0;
      nbits_q <= '0;
      red_q <= '0;
      acc_q <= '0;
      reading_q <= 1'b0;
    end else begin
      // Half period restarts out of WAIT so sampling keeps its margin
      div_q <= (st_q == ADCP_IDLE || st_q == ADCP_WAIT || tick) ?
        '0 : div_q + 1'b1;
      unique case (st_q)
        ADCP_IDLE: if (req_valid) begin
          red_q <= red_clamp;
          edges_q <= adcp_pkg::RES_CW'(red_clamp);
          nbits_q <= '0;
          acc_q <= '0;
          reading_q <= 1'b0;
          clk_q <= 1'b0;
          st_q <= ADCP_LOW;
        end
        ADCP_LOW: if (tick) begin
          clk_q <= 1'b1;
          st_q <= ADCP_HIGH;
        end
        ADCP_HIGH: if (tick) begin
          // Late in the high half: a bit needs about 7 clocks to arrive
          if (reading_q) begin
            acc_q <= {acc_q[adcp_pkg::RES_FULL-2:0], rl_s2_q};
            nbits_q <= nbits_q + 1'b1;
          end
          if (last) begin
            st_q <= reading_q ? ADCP_PUSH : ADCP_WAIT;
          end else begin
            edges_q <= edges_q - 1'b1;
            clk_q <= 1'b0;
            st_q <= ADCP_LOW;
          end
        end
        ADCP_WAIT: if (rl_rise) begin     // Done: line rose
          reading_q <= 1'b1;
          edges_q <= adcp_pkg::RES_CW'(adcp_pkg::RES_FULL) -
            adcp_pkg::RES_CW'(red_q) - 1'b1;
          clk_q <= 1'b0;
          st_q <= ADCP_LOW;
        end
        ADCP_PUSH: if (!full) st_q <= ADCP_IDLE;
        default: st_q <= ADCP_IDLE;
      endcase
    end
  end
  assign link.conv_clk = clk_q;

  // ---------------------------------------------------------------
  // Two-entry result buffer; stalls the sequencer when full
  // ---------------------------------------------------------------
  wire push = (st_q == ADCP_PUSH) && !full;
  wire pop = res_valid && res_ready;
  assign res_valid = (cnt_q != 2'h0);
  assign res_data = buf_q[rd_q];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= '0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= acc_q << (adcp_pkg::RES_FULL - nbits_q);
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : adcp_host

`default_nettype wire

/* adcp_link_sva.sv */
/*
  Checker for the two-wire link: watches the clock line and result line.
  Assumes both ends run on sys_clk with rstn async active low.
*/
`timescale 1ns/1ps
`default_nettype none

module adcp_link_sva #(
  parameter int unsigned REDUCE_WINDOW = 80,
  parameter int unsigned CONV_FULL = 400
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic conv_clk,
  input wire logic result_line
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Longest low run: busy plus a run of zero bits ahead of it
  localparam int unsigned BUSY_MAX = REDUCE_WINDOW + CONV_FULL + 256;
  logic seen_fall_q;
  logic seen_fall_d;
  logic [10:0] low_cnt_q;
  logic [10:0] low_cnt_d;
  logic [4:0] hi_cnt_q;
  logic [4:0] hi_cnt_d;
  logic [4:0] lo_cnt_q;
  logic [4:0] lo_cnt_d;

  // Saturating counts so a hang shows as a fail, not a wrap
  assign seen_fall_d = seen_fall_q | ~conv_clk;
  assign low_cnt_d = result_line ? 11'h000 : low_cnt_q + {10'h000, ~&low_cnt_q};
  assign hi_cnt_d = ~conv_clk ? 5'h00 : hi_cnt_q + {4'h0, ~&hi_cnt_q};
  assign lo_cnt_d = conv_clk ? 5'h00 : lo_cnt_q + {4'h0, ~&lo_cnt_q};

  // Counter registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seen_fall_q <= 1'b0;
      low_cnt_q <= 11'h000;
      hi_cnt_q <= 5'h00;
      lo_cnt_q <= 5'h00;
    end else begin
      seen_fall_q <= seen_fall_d;
      low_cnt_q <= low_cnt_d;
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_idle_lines_high: assert property (
    !seen_fall_q && conv_clk |-> result_line)
    else $error("result line low before any clock fall");
  chk_start_busy_low: assert property (
    $fell(conv_clk) && !seen_fall_q |-> ##[1:16] !result_line)
    else $error("no busy low after start edge");
  chk_start_pattern: assert property (
    $fell(conv_clk) && !seen_fall_q |-> result_line [*8])
    else $error("start pattern not high while clock low");
  chk_busy_bounded: assert property (
    low_cnt_q <= 11'(BUSY_MAX))
    else $error("result line low too long");
  chk_clk_low_width: assert property (
    $fell(conv_clk) |-> !conv_clk [*3])
    else $error("clock low pulse too short");
  chk_clk_high_width: assert property (
    $rose(conv_clk) |-> conv_clk [*3])
    else $error("clock high pulse too short");
  chk_done_holds_high: assert property (
    conv_clk && hi_cnt_q > 5'd10 |-> !$fell(result_line))
    else $error("result line fell with clock idle");
  chk_line_follows_fall: assert property (
    !conv_clk && $changed(result_line) |-> lo_cnt_q <= 5'd8)
    else $error("result line moved long after clock fall");
  chk_line_no_glitch: assert property (
    $changed(result_line) |=> $stable(result_line))
    else $error("one-cycle pulse on result line");

  // Main scenarios reached
  cov_start: cover property ($fell(conv_clk) && !seen_fall_q);
  cov_done: cover property (conv_clk && hi_cnt_q > 5'd10 && $rose(result_line));
  cov_ack: cover property (seen_fall_q && !conv_clk && $rose(result_line));
endmodule : adcp_link_sva

`default_nettype wire

/* tb_adc_two_wire_conversion_port.sv */
/*
  Testbench: host end and converter end joined by the link interface.
  Assumes short sim values for window and conversion length.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_adc_two_wire_conversion_port;
  // Window long enough for six reductions at the host's pace
  localparam int unsigned WIN = 80;
  localparam int unsigned CONV = 400;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic chan_sel_hi = 1'b0;
  logic chan_sel_lo = 1'b0;
  logic [adcp_pkg::RES_FULL-1:0] sample_word = 16'h0000;
  logic [1:0] chan_q;
  logic busy_q;
  logic [4:0] res_q;
  logic req_valid = 1'b0;
  logic req_ready;
  logic [2:0] req_reduce = 3'h0;
  logic res_valid;
  logic res_ready = 1'b0;
  logic [15:0] res_data;
  logic stall = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  logic [15:0] exp_q[$];

  adcp_link_if link();
  adcp_conv #(.REDUCE_WINDOW(WIN), .CONV_FULL(CONV)) i_adcp_conv (
    .sys_clk(sys_clk), .rstn(rstn), .link(link.conv),
    .chan_sel_hi(chan_sel_hi), .chan_sel_lo(chan_sel_lo),
    .sample_word(sample_word), .chan_q(chan_q), .busy_q(busy_q),
    .res_q(res_q));
  adcp_host i_adcp_host (
    .sys_clk(sys_clk), .rstn(rstn), .link(link.host),
    .req_valid(req_valid), .req_ready(req_ready), .req_reduce(req_reduce),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  adcp_link_sva #(.REDUCE_WINDOW(WIN), .CONV_FULL(CONV)) i_adcp_link_sva (
    .sys_clk(sys_clk), .rstn(rstn), .conv_clk(link.conv_clk),
    .result_line(link.result_line));

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // One request; drain waits until its word has been popped
  task automatic run_one(logic [2:0] red, logic [15:0] word, logic [1:0] ch,
                         bit drain);
    int n;
    int k;
    logic [15:0] w;
    n = (red > 3'd6) ? 6 : int'(red);
    w = (word === 16'h8000) ? 16'h8001 : word;
    exp_q.push_back(w & (16'hffff << n));
    @(posedge sys_clk);
    chan_sel_hi <= ch[1];
    chan_sel_lo <= ch[0];
    sample_word <= word;
    req_reduce <= red;
    req_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 4000);
    req_valid <= 1'b0;
    check("req_ready", 16'(req_ready), 16'h1);
    k = 0;
    while (busy_q !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    check("busy_q", 16'(busy_q), 16'h1);
    // Reductions are all in once the window has run out
    repeat (WIN + 16) @(posedge sys_clk);
    check("res_q", 16'(res_q), 16'(16 - n));
    check("chan_q", 16'(chan_q), 16'(ch));
    // Word is taken at completion, so it must stand until busy ends
    k = 0;
    while (busy_q !== 1'b0 && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    check("busy_q end", 16'(busy_q), 16'h0);
    k = 0;
    while (drain && exp_q.size() != 0 && k < 4000) begin
      @(posedge sys_clk);
      k++;
    end
    $display("test done: reduce %0d word %h", red, word);
  endtask : run_one

  // ----------------------------------------------------------------
  // Result watcher with random stalls on the user side
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (res_valid === 1'b1 && res_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("unexpected res_data: expected none seen %h", res_data);
      end else begin
        check("res_data", res_data, exp_q.pop_front());
      end
    end
    res_ready <= !stall && ($urandom % 4 != 0);
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(20 * 60000);
    err_count++;
    $display("unexpected timeout: expected end seen hang");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h3bfd));
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("idle lines", {14'h0, link.conv_clk, link.result_line}, 16'h3);
    // Every reduction count, extremes of the code span first
    for (int i = 0; i < 8; i++) begin
      run_one(3'(i), (i == 0) ? 16'h7fff : (i == 1) ? 16'h8000
              : 16'($urandom), 2'(i), 1'b1);
    end
    // Buffer held full by a stalled receiver, then drained
    stall <= 1'b1;
    run_one(3'h2, 16'h8001, 2'h3, 1'b0);
    run_one(3'h0, 16'($urandom), 2'h1, 1'b0);
    // Third word finds the buffer full and must wait, not be lost
    run_one(3'h6, 16'($urandom), 2'h2, 1'b0);
    repeat (1200) @(posedge sys_clk);
    check("res_valid", 16'(res_valid), 16'h1);
    stall <= 1'b0;
    for (int k = 0; k < 4000 && exp_q.size() != 0; k++) @(posedge sys_clk);
    check("queue left", 16'(exp_q.size()), 16'h0);
    $display("test done: buffer stall");
    print_verdict();
  end
endmodule : tb_adc_two_wire_conversion_port

`default_nettype wire
